// >>> inc/sacc_map.vh
// Purpose: Register map and constants for the converter control block
// Assumes: Avalon-MM word addressing, byte address is four times the index
// Notes: Index values below are register indices, not byte addresses
`ifndef SACC_MAP_VH
`define SACC_MAP_VH

// Register indices
`define SACC_IDX_PIN_SEL 4'h8
`define SACC_IDX_CTRL 4'h9
`define SACC_IDX_RESULT 4'hb
`define SACC_IDX_RES_HI 4'hc
`define SACC_IDX_RES_LO 4'hd
`define SACC_IDX_STATUS 4'he

// Reset values
`define SACC_PIN_SEL_RST 7'h00
`define SACC_CTRL_RST 8'h00
`define SACC_STATUS_RST 3'h0
`define SACC_RESULT_RST 12'h000

// converter_control fields
`define SACC_CTRL_RATE_HI 6
`define SACC_CTRL_RATE_LO 5
`define SACC_CTRL_RUN 4
`define SACC_CTRL_PWR 3
`define SACC_CTRL_CHAN_HI 2
`define SACC_CTRL_CHAN_LO 0

// Status and enable fields
`define SACC_ST_FLAG 0
`define SACC_ST_WAKE_EN 1
`define SACC_ST_IRQ_EN 2

// Clock-rate field encodings and divide ratios
`define SACC_RATE_DIV16 2'b00
`define SACC_RATE_DIV4 2'b01
`define SACC_RATE_DIV64 2'b10
`define SACC_RATE_DIV8 2'b11
`define SACC_DIV16 7'd16
`define SACC_DIV4 7'd4
`define SACC_DIV64 7'd64
`define SACC_DIV8 7'd8

// Conversion timing in converter bit periods
`define SACC_CONV_PERIODS 4'd15
`define SACC_SAMPLE_PERIODS 4'd2
`define SACC_LAST_BIT_PERIOD 4'd13

// Interrupt vector of the converter
`define SACC_IRQ_VECTOR 12'h00c

`endif

// >>> logic/sacc_clk_div.v
// Purpose: Converter clock prescaler giving one-cycle enable pulses
// Assumes: Oscillator is the core clock; rate field is static during a run
// Notes: Restart realigns the first bit period to the start
`include "sacc_map.vh"

module sacc_clk_div (
  input wire core_clk_i, // Oscillator clock
  input wire rst_n_i, // Async reset, active low
  input wire [1:0] rate_i, // Clock-rate field
  input wire restart_i, // Realign counter
  output wire tick_o // One pulse per converter bit period
);

  reg [6:0] cnt_reg;
  wire [6:0] term;

  function [6:0] sacc_div_of;
    input [1:0] rate;
    begin
      case (rate)
        `SACC_RATE_DIV16: sacc_div_of = `SACC_DIV16;
        `SACC_RATE_DIV4: sacc_div_of = `SACC_DIV4;
        `SACC_RATE_DIV64: sacc_div_of = `SACC_DIV64;
        `SACC_RATE_DIV8: sacc_div_of = `SACC_DIV8;
        default: sacc_div_of = `SACC_DIV16;
      endcase
    end
  endfunction

  assign term = sacc_div_of(rate_i) - 7'd1;
  assign tick_o = (cnt_reg == term) && !restart_i;

  // Free running, also while the core sleeps
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 7'h00;
    end else if (restart_i || cnt_reg >= term) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_reg + 7'd1;
    end
  end

endmodule

// >>> logic/sacc_sar.v
// Purpose: Successive-approximation sequencer over fifteen bit periods
// Assumes: Comparator input is already synchronised; high means keep bit
// Notes: Two sample periods, twelve decisions, one load period
`include "sacc_map.vh"

module sacc_sar #(
  parameter WIDTH = 12 // Result width
) (
  input wire core_clk_i, // Oscillator clock
  input wire rst_n_i, // Async reset, active low
  input wire tick_i, // Bit period enable
  input wire start_i, // Start pulse
  input wire comp_i, // Synchronised comparator
  output reg busy_o, // Conversion in progress
  output reg done_o, // One-cycle completion pulse
  output reg sample_o, // Sample switch closed
  output reg [WIDTH-1:0] dac_code_o, // Trial code to the DAC
  output reg [WIDTH-1:0] result_o // Final code, valid with done_o
);

  reg [3:0] period_reg;
  wire [3:0] bit_idx;
  wire [WIDTH-1:0] trial;

  assign bit_idx = `SACC_LAST_BIT_PERIOD - period_reg;
  assign trial = {{(WIDTH-1){1'b0}}, 1'b1} << bit_idx;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_reg <= 4'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      sample_o <= 1'b0;
      dac_code_o <= {WIDTH{1'b0}};
      result_o <= {WIDTH{1'b0}};
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        sample_o <= 1'b1;
        period_reg <= 4'h0;
        dac_code_o <= {WIDTH{1'b0}};
      end else if (busy_o && tick_i) begin
        period_reg <= period_reg + 4'd1;
        if (period_reg == `SACC_SAMPLE_PERIODS - 4'd1) begin
          sample_o <= 1'b0;
          dac_code_o <= {1'b1, {(WIDTH-1){1'b0}}};
        end else if (period_reg >= `SACC_SAMPLE_PERIODS &&
                     period_reg <= `SACC_LAST_BIT_PERIOD) begin
          // Drop the trial bit if the input lies below it, set the next
          if (!comp_i) begin
            dac_code_o <= (dac_code_o & ~trial) | (trial >> 1);
          end else begin
            dac_code_o <= dac_code_o | (trial >> 1);
          end
        end
        if (period_reg == `SACC_LAST_BIT_PERIOD) begin
          result_o <= comp_i ? dac_code_o : (dac_code_o & ~trial);
        end
        if (period_reg == `SACC_CONV_PERIODS - 4'd1) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> logic/sacc_top.v
// Purpose: Control of a 12-bit SAR converter behind an Avalon-MM slave
// Assumes: Core sleep and global enable come from same-clock core logic
// Notes: Every access waits exactly one cycle; reads are registered
`include "sacc_map.vh"

module sacc_top #(
  parameter WIDTH = 12, // Converter resolution
  parameter PINS = 7 // Analog-capable pins
) (
  input wire core_clk_i, // 10 MHz oscillator clock
  input wire rst_n_i, // Async reset, active low
  input wire [3:0] avs_address, // Word index
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_writedata, // Write data
  input wire [3:0] avs_byteenable, // Byte enables
  output reg [31:0] avs_readdata, // Read data
  output wire avs_waitrequest, // Stall request
  input wire core_sleep_i, // Core stopped by sleep instruction
  input wire global_irq_en_i, // Global interrupt enable
  input wire comp_i, // Comparator output from analog
  output reg [PINS-1:0] analog_pin_en_o, // Pin used as analog input
  output reg [PINS-1:0] digital_pin_en_o, // Pin left as digital I/O
  output reg [2:0] channel_o, // Selected input channel
  output reg ref_on_o, // Resistor reference powered
  output wire sample_o, // Sample switch closed
  output wire [WIDTH-1:0] dac_code_o, // Trial code to DAC
  output reg wake_o, // Wake the core
  output reg resume_next_o, // Wake and resume after sleep
  output reg irq_req_o, // Converter interrupt request
  output reg irq_take_o, // Branch to vector allowed
  output reg [11:0] irq_vector_o // Converter interrupt vector
);

  reg ack_reg;
  reg [PINS-1:0] pin_sel_reg;
  reg [1:0] rate_reg;
  reg run_reg;
  reg pwr_reg;
  reg [2:0] chan_reg;
  reg flag_reg;
  reg wake_en_reg;
  reg irq_en_reg;
  reg shut_reg;
  reg [WIDTH-1:0] result_reg;
  reg comp_meta_reg;
  reg comp_sync_reg;
  reg [31:0] rd_next;

  wire req;
  wire wr_ok;
  wire lane0;
  wire wr_ctrl;
  wire wr_pins;
  wire wr_stat;
  wire start;
  wire tick;
  wire done;
  wire busy;
  wire chan_open;
  wire chan_change;
  wire [WIDTH-1:0] sar_result;

  // Same index compare for every write strobe
  function sacc_wr_hit;
    input [3:0] addr;
    input [3:0] idx;
    begin
      sacc_wr_hit = (addr == idx);
    end
  endfunction

  // Request is held until the edge where waitrequest is low
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_ok = avs_write & ack_reg;
  assign lane0 = avs_byteenable[0];
  assign wr_ctrl = wr_ok && lane0 && sacc_wr_hit(avs_address, `SACC_IDX_CTRL);
  assign wr_pins = wr_ok && lane0 && sacc_wr_hit(avs_address, `SACC_IDX_PIN_SEL);
  assign wr_stat = wr_ok && lane0 && sacc_wr_hit(avs_address, `SACC_IDX_STATUS);

  // Ignored while a run is already underway
  assign start = wr_ctrl && avs_writedata[`SACC_CTRL_RUN] && !run_reg;

  assign chan_open = !flag_reg && !run_reg;
  assign chan_change = wr_ctrl && chan_open &&
    avs_writedata[`SACC_CTRL_CHAN_HI:`SACC_CTRL_CHAN_LO] != chan_reg;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Comparator crosses from the analog side
  // Only the second flop feeds the sequencer
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comp_i;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  sacc_clk_div u_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .rate_i(rate_reg),
    .restart_i(start),
    .tick_o(tick)
  );

  sacc_sar #(
    .WIDTH(WIDTH)
  ) u_sar (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .start_i(start),
    .comp_i(comp_sync_reg),
    .busy_o(busy),
    .done_o(done),
    .sample_o(sample_o),
    .dac_code_o(dac_code_o),
    .result_o(sar_result)
  );

  // Control register
  // Rate is taken on any write; keep it static while a run is busy
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_reg <= 2'b00;
      pwr_reg <= 1'b0;
      chan_reg <= 3'h0;
      pin_sel_reg <= `SACC_PIN_SEL_RST;
    end else begin
      if (wr_ctrl) begin
        rate_reg <= avs_writedata[`SACC_CTRL_RATE_HI:`SACC_CTRL_RATE_LO];
        pwr_reg <= avs_writedata[`SACC_CTRL_PWR];
        if (chan_open) begin
          chan_reg <= avs_writedata[`SACC_CTRL_CHAN_HI:`SACC_CTRL_CHAN_LO];
        end
      end
      if (wr_pins) begin
        pin_sel_reg <= avs_writedata[PINS-1:0];
      end
    end
  end

  // Run bit: software may only set it, completion clears it
  // Start needs run low, so it never meets done in the same cycle
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_reg <= 1'b0;
    end else if (done) begin
      run_reg <= 1'b0;
    end else if (start) begin
      run_reg <= 1'b1;
    end
  end

  // Completion flag: set wins over a clearing write
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= 1'b0;
      wake_en_reg <= 1'b0;
      irq_en_reg <= 1'b0;
    end else begin
      if (done) begin
        flag_reg <= 1'b1;
      end else if (wr_stat && !avs_writedata[`SACC_ST_FLAG]) begin
        flag_reg <= 1'b0;
      end
      if (wr_stat) begin
        wake_en_reg <= avs_writedata[`SACC_ST_WAKE_EN];
        irq_en_reg <= avs_writedata[`SACC_ST_IRQ_EN];
      end
    end
  end

  // Result loads with the flag; a channel change wipes it
  // Bytes are not latched as a pair; read them after the flag is set
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_reg <= `SACC_RESULT_RST;
    end else if (done) begin
      result_reg <= sar_result;
    end else if (chan_change) begin
      result_reg <= `SACC_RESULT_RST;
    end
  end

  // Shut-off after a sleeping completion nobody will service
  // Power bit itself stays set; only the reference is gated
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shut_reg <= 1'b0;
    end else if (done && core_sleep_i && !irq_en_reg) begin
      shut_reg <= 1'b1;
    end else if (start || (wr_ctrl && !avs_writedata[`SACC_CTRL_PWR])) begin
      shut_reg <= 1'b0;
    end
  end

  // Read mux, taken on the first edge so data stand at the ack edge
  always @* begin
    rd_next = 32'h0000_0000;
    case (avs_address)
      `SACC_IDX_PIN_SEL: begin
        rd_next[PINS-1:0] = pin_sel_reg;
      end
      `SACC_IDX_CTRL: begin
        rd_next[`SACC_CTRL_RATE_HI:`SACC_CTRL_RATE_LO] = rate_reg;
        rd_next[`SACC_CTRL_RUN] = run_reg;
        rd_next[`SACC_CTRL_PWR] = pwr_reg;
        rd_next[`SACC_CTRL_CHAN_HI:`SACC_CTRL_CHAN_LO] = chan_reg;
      end
      `SACC_IDX_RESULT: begin
        rd_next[7:0] = result_reg[WIDTH-1:WIDTH-8];
      end
      `SACC_IDX_RES_HI: begin
        rd_next[WIDTH-9:0] = result_reg[WIDTH-1:8];
      end
      `SACC_IDX_RES_LO: begin
        rd_next[7:0] = result_reg[7:0];
      end
      `SACC_IDX_STATUS: begin
        rd_next[`SACC_ST_FLAG] = flag_reg;
        rd_next[`SACC_ST_WAKE_EN] = wake_en_reg;
        rd_next[`SACC_ST_IRQ_EN] = irq_en_reg;
      end
      default: begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  // Held after the first edge so data stand at the acknowledge edge
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= rd_next;
    end
  end

  // Registered outputs towards pins, analog and core
  // Core-side levels lag flag and enables by one edge
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_pin_en_o <= {PINS{1'b0}};
      digital_pin_en_o <= {PINS{1'b1}};
      channel_o <= 3'h0;
      ref_on_o <= 1'b0;
      wake_o <= 1'b0;
      resume_next_o <= 1'b0;
      irq_req_o <= 1'b0;
      irq_take_o <= 1'b0;
      irq_vector_o <= 12'h000;
    end else begin
      analog_pin_en_o <= pin_sel_reg;
      digital_pin_en_o <= ~pin_sel_reg;
      channel_o <= chan_reg;
      ref_on_o <= pwr_reg && !shut_reg;
      // Wake is a level held until the core leaves sleep
      wake_o <= core_sleep_i && flag_reg &&
        (wake_en_reg || irq_en_reg);
      resume_next_o <= flag_reg && irq_en_reg && !global_irq_en_i;
      irq_req_o <= flag_reg && irq_en_reg;
      irq_take_o <= flag_reg && irq_en_reg && global_irq_en_i;
      irq_vector_o <= `SACC_IRQ_VECTOR;
    end
  end

endmodule

// >>> tb/sacc_chk.sv
// Purpose: Port-level checks of the converter control block
// Assumes: Core outputs lag their causes by one edge
// Notes: Bound into the top module by name
module sacc_chk #(
  parameter PINS = 7
) (
  input wire core_clk_i, // Clock
  input wire rst_n_i, // Reset, active low
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire avs_waitrequest, // Stall
  input wire core_sleep_i, // Core asleep
  input wire global_irq_en_i, // Global enable
  input wire [PINS-1:0] analog_pin_en_o, // Analog pins
  input wire [PINS-1:0] digital_pin_en_o, // Digital pins
  input wire [2:0] channel_o, // Channel
  input wire sample_o, // Sample switch
  input wire wake_o, // Wake
  input wire resume_next_o, // Resume
  input wire irq_req_o, // Irq request
  input wire irq_take_o, // Branch allowed
  input wire [11:0] irq_vector_o // Vector
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_start;
    $rose(sample_o);
  endsequence
  sequence s_irq_sleep;
    irq_req_o && $past(core_sleep_i);
  endsequence
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus stalled more than one cycle");
  a_pin_inverse: assert property (digital_pin_en_o == ~analog_pin_en_o)
    else $error("digital pins not inverse of analog pins");
  a_vector_fixed: assert property (irq_take_o |-> irq_vector_o == 12'h00c)
    else $error("wrong converter vector");
  a_take_global: assert property (irq_take_o == (irq_req_o && $past(global_irq_en_i)))
    else $error("branch request wrong");
  a_resume_local: assert property (resume_next_o == (irq_req_o && !$past(global_irq_en_i)))
    else $error("resume request wrong");
  a_wake_cause: assert property (wake_o |-> $past(core_sleep_i))
    else $error("wake without sleep");
  a_wake_irq: assert property (s_irq_sleep |-> wake_o)
    else $error("no wake on interrupt in sleep");
  a_chan_hold: assert property (sample_o && $past(sample_o, 2) |-> $stable(channel_o))
    else $error("channel changed during conversion");
  a_sample_len: assert property (s_start |-> sample_o[*8])
    else $error("sample phase too short");
endmodule
bind sacc_top sacc_chk #(.PINS(PINS)) u_chk (.core_clk_i, .rst_n_i, .avs_read, .avs_write,
  .avs_waitrequest, .core_sleep_i, .global_irq_en_i, .analog_pin_en_o, .digital_pin_en_o,
  .channel_o, .sample_o, .wake_o, .resume_next_o, .irq_req_o, .irq_take_o, .irq_vector_o);

// >>> tb/sacc_ana.sv
// Purpose: Behavioural comparator with sample-and-hold
// Assumes: Input level steady while the sample switch is closed
// Notes: Reference off forces the output low, as a dead ladder would
module sacc_ana (
  input wire core_clk_i, // Clock
  input wire sample_i, // Sample switch
  input wire ref_on_i, // Reference powered
  input wire [11:0] vin_i, // Analog level
  input wire [11:0] dac_i, // Trial code
  output logic comp_o // Input at or above code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] held = 12'h000;
  always @(posedge core_clk_i) if (sample_i) held <= vin_i;
  assign comp_o = ref_on_i && (held >= dac_i);
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: One 10 MHz clock; bus master waits for waitrequest low
// Notes: Ideal comparator, so the code equals the input level
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 0;
  logic rst_n_i = 0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic core_sleep_i = 0;
  logic global_irq_en_i = 0;
  logic [11:0] vin = 12'h000;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, comp_i, ref_on_o, sample_o, wake_o, resume_next_o, irq_req_o, irq_take_o;
  wire [6:0] analog_pin_en_o, digital_pin_en_o;
  wire [2:0] channel_o;
  wire [11:0] dac_code_o, irq_vector_o;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 32'h25e1b155;
  int cyc = 0;
  sacc_top dut (.core_clk_i, .rst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .core_sleep_i, .global_irq_en_i, .comp_i,
    .analog_pin_en_o, .digital_pin_en_o, .channel_o, .ref_on_o, .sample_o, .dac_code_o,
    .wake_o, .resume_next_o, .irq_req_o, .irq_take_o, .irq_vector_o);
  sacc_ana ana (.core_clk_i, .sample_i(sample_o), .ref_on_i(ref_on_o), .vin_i(vin),
    .dac_i(dac_code_o), .comp_o(comp_i));
  initial forever #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;
  function automatic int div_of(input logic [1:0] r);
    case (r)
      2'b00: return 16;
      2'b01: return 4;
      2'b10: return 64;
      default: return 8;
    endcase
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [31:0] q);
    logic wt;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    wt = 1;
    for (int n = 0; n < 20 && wt !== 1'b0; n++) begin
      @(posedge core_clk_i);
      wt = avs_waitrequest;
      q = avs_readdata;
    end
    if (wt !== 1'b0) begin
      chk("bus_timeout", 0, 1);
      finish_test;
    end else begin
      avs_write <= 0;
      avs_read <= 0;
      @(posedge core_clk_i);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    bus(0, a, 8'h00, q);
  endtask
  initial begin
    logic [31:0] q;
    logic [7:0] r;
    logic [2:0] ch;
    logic [3:0] ra [5];
    logic ien, gl, slp;
    int d, n, t0;
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1;
    @(posedge core_clk_i);
    ra = '{4'h8, 4'h9, 4'hb, 4'he, 4'h3};
    wr(4'h3, 8'hff);
    for (int k = 0; k < 5; k++) begin
      rd(ra[k], q);
      chk("reset_reg", 0, q);
    end
    chk("digital_pin_en", 32'h7f, digital_pin_en_o);
    r = $random(seed);
    wr(4'h8, r);
    avs_byteenable <= 4'he;
    wr(4'h8, ~r);
    avs_byteenable <= 4'hf;
    rd(4'h8, q);
    chk("pin_sel", r[6:0], q);
    chk("analog_pin_en", r[6:0], analog_pin_en_o);
    chk("digital_pin_en", 7'(~r[6:0]), digital_pin_en_o);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      ch = i[2:0];
      vin <= 12'($random(seed));
      ien = (i != 3);
      gl = i[0];
      slp = i[1];
      d = div_of(i[1:0]);
      global_irq_en_i <= gl;
      wr(4'h9, {1'b0, i[1:0], 2'b01, ch});
      repeat (20) @(posedge core_clk_i);
      wr(4'he, {5'h0, ien, 2'b10});
      wr(4'h9, {1'b0, i[1:0], 2'b11, ch});
      t0 = cyc;
      wr(4'h9, {1'b0, i[1:0], 2'b01, ch ^ 3'h2});
      rd(4'h9, q);
      chk("run_held", 1, q[4]);
      chk("chan_locked", ch, q[2:0]);
      core_sleep_i <= slp;
      while (cyc - t0 < 2000 && (irq_req_o | wake_o) !== 1'b1) begin
        @(posedge core_clk_i);
        @(negedge core_clk_i);
      end
      n = cyc - t0;
      if (n >= 2000) begin
        chk("conv_timeout", 0, 1);
        break;
      end
      chk("conv_cycles", 1, n >= 15 * d && n <= 15 * d + 3);
      chk("wake", slp, wake_o);
      chk("irq_req", ien, irq_req_o);
      chk("irq_take", ien & gl, irq_take_o);
      chk("resume", ien & !gl, resume_next_o);
      chk("vector", 12'h00c, irq_vector_o);
      chk("ref_on", !(slp && !ien), ref_on_o);
      @(posedge core_clk_i);
      core_sleep_i <= 0;
      rd(4'h9, q);
      chk("run", 0, q[4]);
      rd(4'he, q);
      chk("flag", 1, q[0]);
      rd(4'hb, q);
      chk("result", vin[11:4], q);
      rd(4'hc, q);
      chk("result_hi", vin[11:8], q);
      rd(4'hd, q);
      chk("result_lo", vin[7:0], q);
      wr(4'h9, {1'b0, i[1:0], 2'b01, ch ^ 3'h1});
      chk("channel", ch, channel_o);
      wr(4'he, 8'h00);
      rd(4'he, q);
      chk("flag_clr", 0, q[0]);
      chk("irq_req", 0, irq_req_o);
      repeat (2 * d) @(posedge core_clk_i);
      wr(4'h9, {1'b0, i[1:0], 2'b01, ch ^ 3'h1});
      @(posedge core_clk_i);
      chk("channel", ch ^ 3'h1, channel_o);
      rd(4'hd, q);
      chk("result_clr", 0, q);
      $display("test conversion %0d done", i);
    end
    wr(4'h9, 8'h00);
    wr(4'h9, 8'h08);
    @(posedge core_clk_i);
    chk("ref_on", 1, ref_on_o);
    wr(4'h9, 8'h00);
    @(posedge core_clk_i);
    chk("ref_off", 0, ref_on_o);
    $display("test power done");
    finish_test;
  end
endmodule
